// file: rtl/input_check_params.svh
/*
  constants for the input check and alarm configuration register.
  assumes it is included by bare name from the package and the design.
*/
`ifndef INPUT_CHECK_PARAMS_SVH
`define INPUT_CHECK_PARAMS_SVH
`define CTRL_ADDR        7'h01
`define CTRL_RESET       16'h050e
`define BIT_CHECKER      15
`define BIT_AUTO_CLEAR   12
`define BIT_ODD_PARITY   11
`define BIT_WORD_PARITY  10
`define BIT_FRAME_PARITY 9
`define BIT_INVERT_I     6
`define BIT_INVERT_Q     5
`define BIT_GAP_TWO      3
`define BIT_GAP_ONE      2
`define BIT_COLLISION    1
`define GOOD_RUN         7'h40
`endif

// file: rtl/input_check_pkg.sv
/*
  types shared by the input check block and its bench.
  assumes input_check_params.svh is on the include path.
*/
`default_nettype none
package input_check_pkg;
  `include "input_check_params.svh"
  // one received sample with its parity sources
  typedef struct packed {
    logic [15:0] inphase;
    logic [15:0] quadrature;
    logic        check_bit;
    logic        frame;
  } sample_t;
  // sticky alarm flags
  typedef struct packed {
    logic pattern_mismatch;
    logic parity_error;
    logic gap_two;
    logic gap_one;
    logic collision;
  } alarms_t;
  // fifo pointer events
  typedef struct packed {
    logic gap_two;
    logic gap_one;
    logic collision;
  } fifo_events_t;
endpackage
`default_nettype wire

// file: rtl/input_check_alarm_config.sv
/*
  input check and alarm configuration register with the checks it steers:
  pattern checker, parity check, auto alarm clear, channel inversion,
  fifo pointer alarms and output shut-off.
  assumes register writes arrive decoded from the serial configuration
  interface on clk; samples and fifo events are on clk; the transmit
  enable pin is asynchronous and is synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "input_check_params.svh"

// Contract
// - checker bit 15 set runs pattern compare on received words.
// - checker enabled forces both converter outputs off.
// - auto-clear bit 12 clears alarms after 64 consecutive good samples.
// - without auto-clear, alarms hold until software clears them.
// - parity-sense bit 11: zero even, one odd.
// - word-parity bit 10 checks parity of the in-phase word of every received sample.
// - frame-parity bit 9 takes parity bit from frame signal.
// - bit 6 complements in-phase channel data.
// - bit 5 complements quadrature channel data.
// - bit 3 enables the pointers-two-apart alarm.
// - bit 2 enables the pointers-one-apart alarm.
// - bit 1 enables the pointer collision alarm.
// - register at address 0x01, reset value 0x050e.
// - unmasked collision alarm with shut-off enabled and output-gone mask clear turns outputs off.
module input_check_alarm_config
  import input_check_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // register port from the serial interface
  input  wire logic                        reg_write,
  input  wire logic [6:0]                  reg_addr,
  input  wire logic [15:0]                 reg_wdata,
  output logic      [15:0]                 reg_rdata,
  input  wire logic                        alarm_clear,
  // received data path
  input  wire logic                        sample_valid,
  input  wire input_check_pkg::sample_t    sample,
  input  wire logic [15:0]                 expected_inphase,
  input  wire logic [15:0]                 expected_quadrature,
  // fifo pointer events
  input  wire input_check_pkg::fifo_events_t fifo_events,
  // output gating
  input  wire logic                        tx_enable_pin,
  input  wire logic                        sif_tx_enable,
  input  wire logic                        collision_shutoff_enable,
  input  wire logic                        collision_alarm_mask,
  input  wire logic                        output_gone_mask,
  // results
  output input_check_pkg::alarms_t         alarms,
  output logic      [15:0]                 inphase_output,
  output logic      [15:0]                 quadrature_output,
  output logic                             outputs_active
);
  import input_check_pkg::*;

  logic [15:0] ctrl_q;
  alarms_t     alarms_q;
  alarms_t     set_d;
  logic [6:0]  good_q;
  logic        good_run;
  logic        tx_meta_q;
  logic        tx_sync_q;
  logic [15:0] inph_q;
  logic [15:0] quad_q;
  logic        active_q;
  logic        checker_on;
  logic        parity_on;
  logic        parity_src;
  logic        parity_bad;
  logic        pattern_bad;
  logic        shutoff;

  // configuration register, write at its address only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `CTRL_RESET;
    end else if (reg_write && reg_addr == `CTRL_ADDR) begin
      ctrl_q <= reg_wdata;
    end
  end

  // read back: register at its address, else zero
  always_comb begin
    reg_rdata = 16'h0000;
    if (reg_addr == `CTRL_ADDR) begin
      reg_rdata = ctrl_q;
    end
  end

  // pattern check on each received word, parity check on its in-phase word
  assign checker_on  = ctrl_q[`BIT_CHECKER];
  assign pattern_bad = checker_on && sample_valid &&
    ((sample.inphase != expected_inphase) ||
     (sample.quadrature != expected_quadrature));
  assign parity_on   = ctrl_q[`BIT_WORD_PARITY] ||
                       ctrl_q[`BIT_FRAME_PARITY];
  // frame wins as the parity source when selected
  assign parity_src  = ctrl_q[`BIT_FRAME_PARITY] ? sample.frame
                                                  : sample.check_bit;
  // total ones even for even sense, odd for odd sense
  assign parity_bad  = parity_on && sample_valid &&
    ((^sample.inphase ^ parity_src) != ctrl_q[`BIT_ODD_PARITY]);

  // events that set alarm flags this cycle
  always_comb begin
    set_d                  = '0;
    set_d.pattern_mismatch = pattern_bad;
    set_d.parity_error     = parity_bad;
    set_d.gap_two   = fifo_events.gap_two && ctrl_q[`BIT_GAP_TWO];
    set_d.gap_one   = fifo_events.gap_one && ctrl_q[`BIT_GAP_ONE];
    set_d.collision = fifo_events.collision &&
                      ctrl_q[`BIT_COLLISION];
  end

  // run of consecutive error-free samples; restarts once it has cleared
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      good_q <= 7'h00;
    end else if (sample_valid || good_run) begin
      if (pattern_bad || parity_bad || good_run) begin
        good_q <= 7'h00;
      end else begin
        good_q <= good_q + 7'h01;
      end
    end
  end
  assign good_run = ctrl_q[`BIT_AUTO_CLEAR] && (good_q == `GOOD_RUN);

  // sticky alarms; a new event wins over any clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alarms_q <= '0;
    end else if (alarm_clear || good_run) begin
      alarms_q <= set_d;
    end else begin
      alarms_q <= alarms_q | set_d;
    end
  end
  assign alarms = alarms_q;

  // transmit enable pin synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_meta_q <= 1'b0;
      tx_sync_q <= 1'b0;
    end else begin
      tx_meta_q <= tx_enable_pin;
      tx_sync_q <= tx_meta_q;
    end
  end

  // collision shut-off when option on and both alarms unmasked
  assign shutoff = collision_shutoff_enable && !collision_alarm_mask &&
                   !output_gone_mask && alarms_q.collision;

  // output enable: checker or shut-off overrides the enables
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_q <= 1'b0;
    end else begin
      active_q <= tx_sync_q && sif_tx_enable &&
                  !checker_on && !shutoff;
    end
  end
  assign outputs_active = active_q;

  // channel data with optional complement, muted while inactive
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inph_q <= 16'h0000;
      quad_q <= 16'h0000;
    end else if (sample_valid) begin
      inph_q <= ctrl_q[`BIT_INVERT_I] ? ~sample.inphase
                                       : sample.inphase;
      quad_q <= ctrl_q[`BIT_INVERT_Q] ? ~sample.quadrature
                                       : sample.quadrature;
    end
  end
  assign inphase_output    = active_q ? inph_q : 16'h0000;
  assign quadrature_output = active_q ? quad_q : 16'h0000;

  // checks
  reset_value_a: assert property (
    @(posedge clk) $fell(reset) |-> ctrl_q == `CTRL_RESET)
    else $error("control register not at reset value");

  reg_write_a: assert property (
    @(posedge clk) disable iff (reset)
    reg_write && reg_addr == `CTRL_ADDR |=> ctrl_q == $past(reg_wdata))
    else $error("control write not stored");

  checker_mute_a: assert property (
    @(posedge clk) disable iff (reset)
    checker_on |=> !outputs_active)
    else $error("outputs active while checker enabled");

  mismatch_flag_a: assert property (
    @(posedge clk) disable iff (reset)
    checker_on && sample_valid &&
    sample.inphase != expected_inphase |=> alarms.pattern_mismatch)
    else $error("pattern mismatch not flagged");

  parity_sense_a: assert property (
    @(posedge clk) disable iff (reset)
    ctrl_q[`BIT_WORD_PARITY] && !ctrl_q[`BIT_FRAME_PARITY] &&
    sample_valid &&
    ((^sample.inphase ^ sample.check_bit) != ctrl_q[`BIT_ODD_PARITY])
    |=> alarms.parity_error)
    else $error("parity error not flagged");

  frame_parity_a: assert property (
    @(posedge clk) disable iff (reset)
    ctrl_q[`BIT_FRAME_PARITY] && sample_valid &&
    ((^sample.inphase ^ sample.frame) != ctrl_q[`BIT_ODD_PARITY])
    |=> alarms.parity_error)
    else $error("frame parity error not flagged");

  alarm_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    alarms.collision && !alarm_clear && !good_run
    |=> alarms.collision [*1])
    else $error("alarm dropped without clear");

  gap_mask_a: assert property (
    @(posedge clk) disable iff (reset)
    !alarms.gap_one && !ctrl_q[`BIT_GAP_ONE] && !alarm_clear
    |=> !alarms.gap_one)
    else $error("disabled gap alarm raised");

  auto_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    good_run && !(|set_d) |=> alarms == '0)
    else $error("alarms not auto cleared");

  invert_i_a: assert property (
    @(posedge clk) disable iff (reset)
    sample_valid && ctrl_q[`BIT_INVERT_I]
    |=> inph_q == ~$past(sample.inphase))
    else $error("in-phase not complemented");

  shutoff_a: assert property (
    @(posedge clk) disable iff (reset)
    shutoff |=> !outputs_active)
    else $error("collision did not shut off outputs");

  tx_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    !tx_sync_q || !sif_tx_enable |=> !outputs_active)
    else $error("outputs active without transmit enables");

  checker_off_a: assert property (
    @(posedge clk) disable iff (reset)
    !checker_on && !alarms.pattern_mismatch |=> !alarms.pattern_mismatch)
    else $error("mismatch flagged while checker disabled");

  parity_off_a: assert property (
    @(posedge clk) disable iff (reset)
    !parity_on && !alarms.parity_error |=> !alarms.parity_error)
    else $error("parity error flagged while parity check disabled");

  gap_two_a: assert property (
    @(posedge clk) disable iff (reset)
    fifo_events.gap_two && ctrl_q[`BIT_GAP_TWO] |=> alarms.gap_two)
    else $error("enabled two apart alarm not raised");

  gap_one_a: assert property (
    @(posedge clk) disable iff (reset)
    fifo_events.gap_one && ctrl_q[`BIT_GAP_ONE] |=> alarms.gap_one)
    else $error("enabled one apart alarm not raised");

  collision_flag_a: assert property (
    @(posedge clk) disable iff (reset)
    fifo_events.collision && ctrl_q[`BIT_COLLISION] |=> alarms.collision)
    else $error("enabled collision alarm not raised");

  run_restart_a: assert property (
    @(posedge clk) disable iff (reset)
    good_run |=> good_q == 7'h00)
    else $error("good sample run not restarted after auto clear");

  invert_q_a: assert property (
    @(posedge clk) disable iff (reset)
    sample_valid && ctrl_q[`BIT_INVERT_Q]
    |=> quad_q == ~$past(sample.quadrature))
    else $error("quadrature not complemented");

  cover_checker_c: cover property (
    @(posedge clk) disable iff (reset)
    checker_on && pattern_bad);
  cover_autoclear_c: cover property (
    @(posedge clk) disable iff (reset)
    good_run && |alarms_q);
  cover_parity_c: cover property (
    @(posedge clk) disable iff (reset) parity_bad);
  cover_shutoff_c: cover property (
    @(posedge clk) disable iff (reset) shutoff && tx_sync_q);
  cover_invert_c: cover property (
    @(posedge clk) disable iff (reset) sample_valid && ctrl_q[`BIT_INVERT_Q]);
endmodule
`default_nettype wire

// file: bench/tb_input_check_alarm_config.sv
/*
  self-checking bench for the input check and alarm configuration block.
  assumes the package and params header from rtl/ on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "input_check_params.svh"
module tb_input_check_alarm_config;
  import input_check_pkg::*;
  logic         clk;
  logic         reset;
  logic         reg_write;
  logic         alarm_clear;
  logic         sample_valid;
  logic [6:0]   reg_addr;
  logic [15:0]  reg_wdata;
  logic [15:0]  reg_rdata;
  logic [15:0]  exp_i;
  logic [15:0]  exp_q;
  logic [15:0]  out_i;
  logic [15:0]  out_q;
  sample_t      sample;
  fifo_events_t fifo_events;
  logic         shut_en;
  logic         coll_mask;
  logic         gone_mask;
  logic         tx_pin;
  logic         sif_en;
  logic         active;
  alarms_t      alarms;
  int           n_errors;
  int           checked;

  // device under test
  input_check_alarm_config u_dut (
    .clk(clk), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alarm_clear(alarm_clear),
    .sample_valid(sample_valid), .sample(sample), .expected_inphase(exp_i),
    .expected_quadrature(exp_q), .fifo_events(fifo_events),
    .tx_enable_pin(tx_pin), .sif_tx_enable(sif_en),
    .collision_shutoff_enable(shut_en), .collision_alarm_mask(coll_mask),
    .output_gone_mask(gone_mask), .alarms(alarms), .inphase_output(out_i),
    .quadrature_output(out_q), .outputs_active(active));

  // 50 MHz clock
  always #10 clk = ~clk;

  // shared compare, drivers and closing
  task automatic chk(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr  <= 7'h01;
    #1;
  endtask
  task automatic send(input logic [15:0] i, q, input logic cb, fr);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample       <= {i, q, cb, fr};
    @(posedge clk);
    sample_valid <= 1'b0;
    #1;
  endtask
  task automatic stream(input int n);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample       <= '0;
    repeat (n) @(posedge clk);
    sample_valid <= 1'b0;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clr;
    @(posedge clk);
    alarm_clear <= 1'b1;
    @(posedge clk);
    alarm_clear <= 1'b0;
    #1;
  endtask
  task automatic fifo(input logic [2:0] v);
    @(posedge clk);
    fifo_events <= v;
    @(posedge clk);
    fifo_events <= '0;
    #1;
  endtask

  // scenarios
  task automatic t_reset;
    chk("outputs_active", active, 0);
    chk("ctrl default", reg_rdata, `CTRL_RESET);
    wr(7'h02, 16'hffff);
    chk("ctrl after stray write", reg_rdata, `CTRL_RESET);
    @(posedge clk);
    reg_addr <= 7'h02;
    #1 chk("unmapped read", reg_rdata, 0);
    wr(7'h01, 16'h1234);
    chk("ctrl readback", reg_rdata, 16'h1234);
    @(posedge clk);
    reset <= 1'b1;
    idle(2);
    chk("ctrl after mid reset", reg_rdata, `CTRL_RESET);
    chk("active after mid reset", active, 0);
    @(posedge clk);
    reset <= 1'b0;
    #1;
    $display("reset and register test done");
  endtask
  task automatic t_parity;
    logic [15:0] cfg;
    for (int s = 0; s < 2; s++) for (int f = 0; f < 2; f++)
      for (int p = 0; p < 2; p++) begin
        cfg = (f != 0) ? 16'h0200 : 16'h0400;
        wr(7'h01, cfg | (s != 0 ? 16'h0800 : 16'h0000));
        clr();
        send(16'h0001, 16'h0, (f != 0) ? !p[0] : p[0],
             (f != 0) ? p[0] : !p[0]);
        chk("parity_error", alarms.parity_error, ((1 ^ p) != s));
      end
    wr(7'h01, 16'h0000);
    clr();
    send(16'h0001, 16'h0, 1'b0, 1'b0);
    chk("parity off", alarms.parity_error, 0);
    $display("parity test done");
  endtask
  task automatic t_pattern;
    @(posedge clk);
    sif_en <= 1'b0;
    idle(2);
    chk("outputs_active sif off", active, 0);
    @(posedge clk);
    sif_en <= 1'b1;
    tx_pin <= 1'b0;
    idle(4);
    chk("outputs_active pin off", active, 0);
    @(posedge clk);
    tx_pin <= 1'b1;
    idle(4);
    chk("outputs_active", active, 1);
    wr(7'h01, 16'h8000);
    idle(2);
    chk("outputs_active checker", active, 0);
    send(16'h00aa, 16'h5500, 1'b0, 1'b0);
    chk("alarms match", alarms, 0);
    send(16'h00aa, 16'h5501, 1'b0, 1'b0);
    chk("pattern_mismatch", alarms.pattern_mismatch, 1);
    $display("pattern test done");
  endtask
  task automatic t_clear;
    wr(7'h01, 16'h0400);
    clr();
    send(16'h0001, 16'h0, 1'b0, 1'b0);
    stream(70);
    chk("sticky alarm", alarms, 5'h08);
    clr();
    chk("cleared alarm", alarms, 0);
    wr(7'h01, 16'h1400);
    send(16'h0001, 16'h0, 1'b0, 1'b0);
    stream(64);
    chk("before auto clear", alarms, 5'h08);
    idle(1);
    chk("after auto clear", alarms, 0);
    $display("alarm clear test done");
  endtask
  task automatic t_invert;
    wr(7'h01, 16'h0000);
    idle(4);
    send(16'h1234, 16'h00ff, 1'b0, 1'b0);
    chk("inphase plain", out_i, 16'h1234);
    chk("quadrature plain", out_q, 16'h00ff);
    wr(7'h01, 16'h0060);
    send(16'h1234, 16'h00ff, 1'b0, 1'b0);
    chk("inphase inverted", out_i, 16'hedcb);
    chk("quadrature inverted", out_q, 16'hff00);
    $display("inversion test done");
  endtask
  task automatic t_fifo;
    wr(7'h01, 16'h000e);
    for (int k = 0; k < 3; k++) begin
      clr();
      fifo(3'b001 << k);
      chk("fifo alarm", alarms[2:0], 3'b001 << k);
    end
    wr(7'h01, 16'h0000);
    clr();
    fifo(3'b111);
    chk("fifo alarm off", alarms, 0);
    wr(7'h01, 16'h0002);
    @(posedge clk);
    shut_en <= 1'b1;
    idle(4);
    fifo(3'b001);
    idle(3);
    chk("shut off", active, 0);
    @(posedge clk);
    coll_mask <= 1'b1;
    idle(4);
    chk("masked shut off", active, 1);
    @(posedge clk);
    coll_mask <= 1'b0;
    gone_mask <= 1'b1;
    idle(4);
    chk("gone masked shut off", active, 1);
    $display("fifo alarm test done");
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {reg_write, alarm_clear, sample_valid, shut_en, coll_mask} = '0;
    gone_mask = 1'b0;
    tx_pin = 1'b1;
    sif_en = 1'b1;
    reg_addr = 7'h01;
    reg_wdata = '0;
    sample = '0;
    fifo_events = '0;
    exp_i = 16'h00aa;
    exp_q = 16'h5500;
    n_errors = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_parity();
    t_pattern();
    t_clear();
    t_invert();
    t_fifo();
    tally_and_finish();
  end
endmodule
`default_nettype wire
